/* File: design/i2c_mem_pkg.sv */
// Purpose: shared constants and types for the two-wire byte memory slave port
// Assumes: 11-bit byte address split as 3-bit page over 8-bit row offset
// Notes: behaviour summary follows
// Notes on behaviour
// [R01] 2048 bytes, 11-bit address: page plus row
// [R02] each write done long before next transfer
// [R03] slave only; master drives the serial clock
// [R04] data rising with clock high is stop; aborts
// [R05] data falling with clock high is start
// [R06] start aborts everything, awaits slave address
// [R07] master should start after supply brownout
// [R08] data stable while clock high; sampled then
// [R09] receiver pulls data low in ninth clock
// [R10] missing acknowledge aborts, device addressable again
// [R11] read continues while master acknowledges bytes
// [R12] first byte: type, page select, direction
// [R13] direction one reads, zero writes
// [R14] write: word byte joins page into latch
// [R15] read: page from address, low bits kept
// [R16] latch increments after each data byte
// [R17] latch wraps from top to zero
// [R18] no limit on bytes per operation
// [R19] read: drive eight bits, then sample acknowledge
// [R20] write: take eight bits, then acknowledge
// [R21] all bytes most significant bit first
// [R22] sample on clock rise, drive on fall
// [R23] commit write at eighth bit, before acknowledge
// [R24] repeated start keeps loaded address for read
// [R25] wrong device type: no acknowledge, ignore bus
package i2c_mem_pkg;
    localparam int ADDR_W = 11;            // full byte address width
    localparam int ROW_W = 8;              // word address byte width
    localparam int PAGE_W = 3;             // page select width
    localparam int TYPE_W = 4;             // device type field width
    localparam int BYTE_W = 8;             // bits per byte
    localparam int CNT_W = 4;              // bit counter width
    localparam logic [3:0] CNT_LAST = 4'h7;  // index of eighth bit
    localparam logic [3:0] CNT_ACK = 4'h8;   // eight bits taken, ack next
    localparam logic [3:0] CNT_ACKHI = 4'h9; // ack clock has risen
    localparam int TYPE_MSB = 7;           // device type field top bit
    localparam int PAGE_LSB = 1;           // page select lowest bit
    localparam int RW_BIT = 0;             // direction flag position
    localparam logic [10:0] ADDR_RST = 11'h000; // address latch reset value
    localparam logic [7:0] BYTE_RST = 8'h00;    // data register reset value
    localparam logic [3:0] TYPE_DEFAULT = 4'h5; // arbitrary neutral type code

    // one memory access handed from the link side to the memory side
    typedef struct packed {
        logic we;                  // one writes, zero reads
        logic [10:0] addr;         // byte address
        logic [7:0] wdata;         // write data
    } mem_cmd_t;

    // link side protocol phases
    typedef enum logic [2:0] {
        ST_IDLE,                   // ignoring bus until start
        ST_DEV,                    // taking slave address byte
        ST_WORD,                   // taking word address byte
        ST_WDATA,                  // taking write data bytes
        ST_RDATA                   // sending read data bytes
    } link_state_t;
endpackage

/* File: design/i2c_mem_port.sv */
// Purpose: memory-clock side of the access handshake
// Assumes: memory returns read data one clk after the strobe
// Notes: command is held stable by the link side until ack toggles back
`timescale 1ns/10ps
`default_nettype none
module i2c_mem_port (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic req_tgl,
    input wire i2c_mem_pkg::mem_cmd_t cmd_in,
    output logic ack_tgl,
    output logic [7:0] rdata_held,
    output logic mem_stb,
    output i2c_mem_pkg::mem_cmd_t mem_cmd,
    input wire logic [7:0] mem_rdata
);
    logic req_s1_q; // first sync stage
    logic req_s2_q; // second sync stage
    logic req_s3_q; // last seen toggle
    logic rd_wait_q; // read data due this cycle

    // two-flop synchroniser for the request toggle
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            req_s1_q <= 1'b0;
            req_s2_q <= 1'b0;
            req_s3_q <= 1'b0;
        end
        else
        begin
            req_s1_q <= req_tgl;
            req_s2_q <= req_s1_q;
            req_s3_q <= req_s2_q;
        end
    end

    // issue the access, write commits here  see [R23]
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            mem_stb <= 1'b0;
            mem_cmd <= '0;
        end
        else
        begin
            mem_stb <= req_s2_q ^ req_s3_q; // one access per toggle  see [R02]
            if (req_s2_q ^ req_s3_q)
            begin
                mem_cmd <= cmd_in;
            end
        end
    end

    // capture read data, then answer with the ack toggle
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rd_wait_q <= 1'b0;
            rdata_held <= i2c_mem_pkg::BYTE_RST;
            ack_tgl <= 1'b0;
        end
        else
        begin
            rd_wait_q <= mem_stb && !mem_cmd.we;
            if (rd_wait_q)
            begin
                rdata_held <= mem_rdata;
            end
            // writes answer at once, reads after the data lands
            if ((mem_stb && mem_cmd.we) || rd_wait_q)
            begin
                ack_tgl <= ~ack_tgl;
            end
        end
    end
endmodule
`default_nettype wire

/* File: design/i2c_mem_slave.sv */
// Purpose: two-wire slave front end of a 2K x 8 byte memory
// Assumes: link_clk is a free running sample clock far above the serial clock
// Notes: memory array sits outside on the clk side; write protect not built
`timescale 1ns/10ps
`default_nettype none
module i2c_mem_slave #(
    parameter logic [3:0] DEV_TYPE = i2c_mem_pkg::TYPE_DEFAULT // arbitrary value
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic link_clk,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    output logic mem_stb,
    output i2c_mem_pkg::mem_cmd_t mem_cmd,
    input wire logic [7:0] mem_rdata
);
    // pin synchronisers and edge history
    logic scl_s1_q; // first stage, read only by second
    logic scl_s2_q; // synchronised clock line
    logic scl_s3_q; // previous clock line
    logic sda_s1_q; // first stage, read only by second
    logic sda_s2_q; // synchronised data line
    logic sda_s3_q; // previous data line
    logic scl_rise; // clock line rose
    logic scl_fall; // clock line fell
    logic start_det; // start condition seen
    logic stop_det; // stop condition seen

    // protocol state
    i2c_mem_pkg::link_state_t state_q; // current phase
    logic [3:0] cnt_q; // clock rises in this byte
    logic [7:0] shift_q; // byte shifter
    logic [7:0] next_byte; // byte including the bit now sampled
    logic [10:0] addr_q; // internal address latch
    logic [2:0] page_q; // page from slave address
    logic rw_q; // direction of current operation
    logic ack_pend_q; // we owe an acknowledge this slot
    logic oe_q; // data line pulled low

    // access handshake towards the memory side
    logic req_tgl_q; // toggles once per access
    i2c_mem_pkg::mem_cmd_t cmd_q; // held stable for the memory side
    logic ack_tgl; // memory side answer toggle
    logic [7:0] rdata_held; // read data held by memory side
    logic ack_s1_q; // first sync stage
    logic ack_s2_q; // second sync stage
    logic ack_s3_q; // last seen answer
    logic [7:0] prefetch_q; // next byte to send

    // two flops on each pin before any logic reads them
    always_ff @(posedge link_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            scl_s1_q <= 1'b1;
            scl_s2_q <= 1'b1;
            scl_s3_q <= 1'b1;
            sda_s1_q <= 1'b1;
            sda_s2_q <= 1'b1;
            sda_s3_q <= 1'b1;
        end
        else
        begin
            scl_s1_q <= scl_i;
            scl_s2_q <= scl_s1_q;
            scl_s3_q <= scl_s2_q;
            sda_s1_q <= sda_i;
            sda_s2_q <= sda_s1_q;
            sda_s3_q <= sda_s2_q;
        end
    end

    // bus events; the master owns the clock line  see [R03]
    assign scl_rise = scl_s2_q && !scl_s3_q;
    assign scl_fall = !scl_s2_q && scl_s3_q;
    assign start_det = scl_s2_q && scl_s3_q && !sda_s2_q && sda_s3_q; // see [R05]
    assign stop_det = scl_s2_q && scl_s3_q && sda_s2_q && !sda_s3_q; // see [R04]
    assign next_byte = {shift_q[6:0], sda_s2_q}; // msb first  see [R21]

    // main protocol engine on the link clock
    always_ff @(posedge link_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_q <= i2c_mem_pkg::ST_IDLE;
            cnt_q <= '0;
            shift_q <= i2c_mem_pkg::BYTE_RST;
            addr_q <= i2c_mem_pkg::ADDR_RST;
            page_q <= '0;
            rw_q <= 1'b0;
            ack_pend_q <= 1'b0;
            oe_q <= 1'b0;
            req_tgl_q <= 1'b0;
            cmd_q <= '0;
        end
        else if (start_det)
        begin
            // abort anything, await slave address; latch kept  see [R06] see [R24]
            state_q <= i2c_mem_pkg::ST_DEV;
            cnt_q <= '0;
            oe_q <= 1'b0;
            ack_pend_q <= 1'b0;
        end
        else if (stop_det)
        begin
            // abort and go quiet  see [R04]
            state_q <= i2c_mem_pkg::ST_IDLE;
            cnt_q <= '0;
            oe_q <= 1'b0;
            ack_pend_q <= 1'b0;
        end
        else if (scl_rise && state_q != i2c_mem_pkg::ST_IDLE)
        begin
            // sample on rising clock  see [R22] see [R08]
            if (cnt_q == i2c_mem_pkg::CNT_ACK)
            begin
                cnt_q <= i2c_mem_pkg::CNT_ACKHI;
                // master left the slot high: end the read  see [R11] see [R10]
                if (state_q == i2c_mem_pkg::ST_RDATA && sda_s2_q)
                begin
                    state_q <= i2c_mem_pkg::ST_IDLE;
                    cnt_q <= '0;
                end
            end
            else if (cnt_q < i2c_mem_pkg::CNT_ACK)
            begin
                cnt_q <= cnt_q + 4'h1;
                if (state_q != i2c_mem_pkg::ST_RDATA)
                begin
                    shift_q <= next_byte;
                end
                if (cnt_q == i2c_mem_pkg::CNT_LAST)
                begin
                    unique case (state_q)
                        i2c_mem_pkg::ST_DEV:
                        begin
                            // type, page, direction  see [R12] see [R13]
                            if (next_byte[7:4] == DEV_TYPE)
                            begin
                                page_q <= next_byte[3:1];
                                rw_q <= next_byte[0];
                                ack_pend_q <= 1'b1;
                                if (next_byte[0])
                                begin
                                    // page from address, row from latch  see [R15]
                                    addr_q <= {next_byte[3:1], addr_q[7:0]};
                                    cmd_q <= '{we: 1'b0,
                                               addr: {next_byte[3:1], addr_q[7:0]},
                                               wdata: i2c_mem_pkg::BYTE_RST};
                                    req_tgl_q <= ~req_tgl_q;
                                end
                            end
                            else
                            begin
                                // not ours: stay silent until start  see [R25]
                                state_q <= i2c_mem_pkg::ST_IDLE;
                                cnt_q <= '0;
                            end
                        end
                        i2c_mem_pkg::ST_WORD:
                        begin
                            // 11-bit latch = page and word byte  see [R14] see [R01]
                            addr_q <= {page_q, next_byte};
                            ack_pend_q <= 1'b1;
                        end
                        i2c_mem_pkg::ST_WDATA:
                        begin
                            // commit at eighth bit, step latch, wraps  see [R23] see [R16] see [R17]
                            cmd_q <= '{we: 1'b1, addr: addr_q, wdata: next_byte};
                            req_tgl_q <= ~req_tgl_q;
                            addr_q <= addr_q + 11'h001;
                            ack_pend_q <= 1'b1;
                        end
                        i2c_mem_pkg::ST_RDATA:
                        begin
                            // step latch, fetch following byte  see [R16] see [R17]
                            addr_q <= addr_q + 11'h001;
                            cmd_q <= '{we: 1'b0, addr: addr_q + 11'h001,
                                       wdata: i2c_mem_pkg::BYTE_RST};
                            req_tgl_q <= ~req_tgl_q;
                        end
                        default:
                        begin
                            cnt_q <= '0;
                        end
                    endcase
                end
            end
        end
        else if (scl_fall && state_q != i2c_mem_pkg::ST_IDLE)
        begin
            // change outputs on falling clock  see [R22]
            if (cnt_q == i2c_mem_pkg::CNT_ACK)
            begin
                // receiver pulls low for the ack clock  see [R09] see [R20]
                oe_q <= ack_pend_q && state_q != i2c_mem_pkg::ST_RDATA;
            end
            else if (cnt_q == i2c_mem_pkg::CNT_ACKHI)
            begin
                cnt_q <= '0;
                ack_pend_q <= 1'b0;
                oe_q <= 1'b0;
                unique case (state_q)
                    i2c_mem_pkg::ST_DEV:
                    begin
                        if (rw_q)
                        begin
                            state_q <= i2c_mem_pkg::ST_RDATA;
                            shift_q <= prefetch_q;
                            oe_q <= !prefetch_q[7];
                        end
                        else
                        begin
                            state_q <= i2c_mem_pkg::ST_WORD;
                        end
                    end
                    i2c_mem_pkg::ST_WORD:
                    begin
                        state_q <= i2c_mem_pkg::ST_WDATA;
                    end
                    i2c_mem_pkg::ST_RDATA:
                    begin
                        // acked: send next byte, no count limit  see [R19] see [R18]
                        shift_q <= prefetch_q;
                        oe_q <= !prefetch_q[7];
                    end
                    default:
                    begin
                        // write data keeps going  see [R18]
                        state_q <= state_q;
                    end
                endcase
            end
            else if (state_q == i2c_mem_pkg::ST_RDATA && cnt_q != 4'h0)
            begin
                // next bit msb first; release for master ack  see [R21] see [R09]
                shift_q <= {shift_q[6:0], 1'b0};
                oe_q <= (cnt_q < i2c_mem_pkg::CNT_ACK) && !shift_q[6];
            end
        end
    end

    // answer toggle back to the link side, then take read data
    always_ff @(posedge link_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ack_s1_q <= 1'b0;
            ack_s2_q <= 1'b0;
            ack_s3_q <= 1'b0;
            prefetch_q <= i2c_mem_pkg::BYTE_RST;
        end
        else
        begin
            ack_s1_q <= ack_tgl;
            ack_s2_q <= ack_s1_q;
            ack_s3_q <= ack_s2_q;
            // held data is stable once the toggle arrives
            if (ack_s2_q ^ ack_s3_q)
            begin
                prefetch_q <= rdata_held;
            end
        end
    end

    // open-drain pin: only ever pulls low
    always_ff @(posedge link_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sda_o <= 1'b0;
            sda_oe <= 1'b0;
        end
        else
        begin
            sda_o <= 1'b0;
            sda_oe <= oe_q;
        end
    end

    // memory clock side of the handshake
    i2c_mem_port u_port (
        .clk(clk),
        .arst_n(arst_n),
        .req_tgl(req_tgl_q),
        .cmd_in(cmd_q),
        .ack_tgl(ack_tgl),
        .rdata_held(rdata_held),
        .mem_stb(mem_stb),
        .mem_cmd(mem_cmd),
        .mem_rdata(mem_rdata)
    );
endmodule
`default_nettype wire

/* File: tb/i2c_mem_slave_checker.sv */
// Purpose: protocol checker for the two-wire memory slave port
// Assumes: link side runs on link_clk, memory side on clk
// Notes: bound to the slave from the bench top
`timescale 1ns/10ps
`default_nettype none
module i2c_mem_slave_checker (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic link_clk,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe,
    input wire logic mem_stb,
    input wire i2c_mem_pkg::mem_cmd_t mem_cmd,
    input wire logic [7:0] mem_rdata
);
    // open drain: the port only ever pulls low
    a_pull_low_only: assert property (@(posedge link_clk) disable iff (!arst_n)
        sda_o == 1'b0) else $error("sda_o driven high");
    // device starts driving only while clock is low
    a_oe_rise_low: assert property (@(posedge link_clk) disable iff (!arst_n)
        $rose(sda_oe) |-> !scl_i) else $error("sda_oe rose with clock high");
    // a driven bit stays at least four link clocks
    a_oe_hold: assert property (@(posedge link_clk) disable iff (!arst_n)
        $rose(sda_oe) |=> sda_oe [*4]) else $error("sda_oe dropped early");
    // a driven low never outlasts one data byte
    a_oe_bound: assert property (@(posedge link_clk) disable iff (!arst_n)
        $rose(sda_oe) |-> ##[1:250] !sda_oe) else $error("sda_oe stuck high");
    // stop releases the data line
    a_stop_free: assert property (@(posedge link_clk) disable iff (!arst_n)
        (scl_i && $past(scl_i) && $rose(sda_i)) |-> ##[1:8] !sda_oe)
        else $error("line held after stop");
    // start releases the data line
    a_start_free: assert property (@(posedge link_clk) disable iff (!arst_n)
        (scl_i && $past(scl_i) && $fell(sda_i)) |-> ##[1:8] !sda_oe)
        else $error("line held after start");
    // one access per byte, strobes well apart
    a_stb_single: assert property (@(posedge clk) disable iff (!arst_n)
        mem_stb |=> !mem_stb [*3]) else $error("strobe too long or too close");
    // command only moves with its strobe
    a_cmd_held: assert property (@(posedge clk) disable iff (!arst_n)
        !mem_stb |-> $stable(mem_cmd)) else $error("command changed without strobe");
    // main scenarios reached
    c_write: cover property (@(posedge clk) disable iff (!arst_n) mem_stb && mem_cmd.we);
    c_read: cover property (@(posedge clk) disable iff (!arst_n) mem_stb && !mem_cmd.we);
    c_drive: cover property (@(posedge link_clk) disable iff (!arst_n) $rose(sda_oe));
endmodule
`default_nettype wire

/* File: tb/i2c_master_model.sv */
// Purpose: behavioural bus master driving the serial clock and data
// Assumes: open-drain data line with pull-up resolved in the bench
// Notes: clock stands high between frames
`timescale 1ns/10ps
`default_nettype none
module i2c_master_model #(
    parameter int H = 10 // link clocks per clock phase
) (
    input wire logic link_clk,
    input wire logic sda,
    output logic scl,
    output logic sda_drv
);
    // idle bus: clock high, data released
    initial
    begin
        scl = 1'b1;
        sda_drv = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge link_clk);
    endtask
    // start or repeated start, leaves clock low
    task automatic start_c();
        sda_drv <= 1'b0;
        tick(H);
        scl <= 1'b1;
        tick(H);
        sda_drv <= 1'b1;
        tick(H);
        scl <= 1'b0;
        tick(H);
    endtask
    // stop: data rises with clock high
    task automatic stop_c();
        sda_drv <= 1'b1;
        tick(H);
        scl <= 1'b1;
        tick(H);
        sda_drv <= 1'b0;
        tick(H);
    endtask
    // one bit: data set while low, sampled mid high
    task automatic bit_io(input logic b, output logic r);
        sda_drv <= !b;
        tick(H);
        scl <= 1'b1;
        tick(H / 2);
        r = sda;
        tick(H / 2);
        scl <= 1'b0;
        tick(2);
    endtask
    task automatic send_byte(input logic [7:0] v, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(v[i], r);
        bit_io(1'b1, r);
        ack = !r;
    endtask
    task automatic recv_byte(input logic ack, output logic [7:0] v);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            bit_io(1'b1, r);
            v[i] = r;
        end
        bit_io(!ack, r);
    endtask
endmodule
`default_nettype wire

/* File: tb/test_i2c_mem_slave.sv */
// Purpose: self-checking bench for the two-wire memory slave
// Assumes: memory array modelled here with one clk read latency
// Notes: memory preset to address xor 5c
`timescale 1ns/10ps
`default_nettype none
module test_i2c_mem_slave;
    localparam logic [3:0] DT = 4'h3; // arbitrary device type
    logic clk = 1'b0;
    logic link_clk = 1'b0;
    logic arst_n = 1'b0;
    logic scl; // serial clock from master
    logic m_drv; // master pulling data low
    logic sda_w; // resolved data wire
    logic sda_o;
    logic sda_oe;
    logic mem_stb;
    i2c_mem_pkg::mem_cmd_t mem_cmd;
    logic [7:0] mem_rdata = 8'h00;
    logic [7:0] mem [2048]; // backing array
    int failures = 0;
    int n_checks = 0;
    // wired-and with pull-up
    assign sda_w = !(m_drv || (sda_oe && !sda_o));
    initial forever #10 clk = ~clk;
    initial
    begin
        #3;
        forever #6 link_clk = ~link_clk;
    end
    // memory: write on strobe, read data next edge
    always @(posedge clk)
    begin
        if (mem_stb && mem_cmd.we)
            mem[mem_cmd.addr] <= mem_cmd.wdata;
        if (mem_stb)
            mem_rdata <= mem[mem_cmd.addr];
    end
    i2c_mem_slave #(.DEV_TYPE(DT)) i2c_mem_slave_inst (.clk(clk), .arst_n(arst_n),
        .link_clk(link_clk), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe),
        .mem_stb(mem_stb), .mem_cmd(mem_cmd), .mem_rdata(mem_rdata));
    i2c_master_model #(.H(10)) i2c_master_model_inst (.link_clk(link_clk), .sda(sda_w),
        .scl(scl), .sda_drv(m_drv));
    task automatic check(input string what, input logic [10:0] got, input logic [10:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    function automatic logic [7:0] sa(input logic [2:0] pg, input logic rw);
        return {DT, pg, rw};
    endfunction
    task automatic sb(input logic [7:0] v, input logic ea);
        logic a;
        i2c_master_model_inst.send_byte(v, a);
        check("ack", {10'h0, a}, {10'h0, ea});
    endtask
    task automatic rb(input logic ack, input logic [7:0] e);
        logic [7:0] v;
        i2c_master_model_inst.recv_byte(ack, v);
        check("rdata", {3'h0, v}, {3'h0, e});
    endtask
    // start, addressed write, a few bits, then cut short
    task automatic part(input logic [7:0] wa);
        logic r;
        i2c_master_model_inst.start_c();
        sb(sa(3'h1, 1'b0), 1'b1);
        sb(wa, 1'b1);
        repeat (4) i2c_master_model_inst.bit_io(1'b0, r);
    endtask
    // sequential write crossing a page edge
    task automatic t_write();
        i2c_master_model_inst.start_c();
        sb(sa(3'h3, 1'b0), 1'b1);
        sb(8'hfe, 1'b1);
        sb(8'ha5, 1'b1);
        sb(8'h3c, 1'b1);
        sb(8'h96, 1'b1);
        i2c_master_model_inst.stop_c();
        check("m3fe", {3'h0, mem[11'h3fe]}, 11'h0a5);
        check("m3ff", {3'h0, mem[11'h3ff]}, 11'h03c);
        check("m400", {3'h0, mem[11'h400]}, 11'h096);
        $display("t_write done");
    endtask
    // random read via repeated start
    task automatic t_read();
        i2c_master_model_inst.start_c();
        sb(sa(3'h3, 1'b0), 1'b1);
        sb(8'hfe, 1'b1);
        i2c_master_model_inst.start_c();
        sb(sa(3'h3, 1'b1), 1'b1);
        rb(1'b1, 8'ha5);
        rb(1'b0, 8'h3c);
        i2c_master_model_inst.stop_c();
        $display("t_read done");
    endtask
    // wrap at the top, then current address read
    task automatic t_wrap();
        i2c_master_model_inst.start_c();
        sb(sa(3'h7, 1'b0), 1'b1);
        sb(8'hff, 1'b1);
        sb(8'h5a, 1'b1);
        sb(8'h7e, 1'b1);
        i2c_master_model_inst.stop_c();
        check("m7ff", {3'h0, mem[11'h7ff]}, 11'h05a);
        check("m000", {3'h0, mem[11'h000]}, 11'h07e);
        i2c_master_model_inst.start_c();
        sb(sa(3'h0, 1'b1), 1'b1);
        rb(1'b0, 8'h5d);
        i2c_master_model_inst.stop_c();
        $display("t_wrap done");
    endtask
    // partial bytes cut by stop and by start
    task automatic t_abort();
        part(8'h10);
        i2c_master_model_inst.stop_c();
        check("m110", {3'h0, mem[11'h110]}, 11'h04c);
        part(8'h20);
        i2c_master_model_inst.start_c();
        sb(sa(3'h1, 1'b1), 1'b1);
        rb(1'b0, 8'h7c);
        i2c_master_model_inst.stop_c();
        check("m120", {3'h0, mem[11'h120]}, 11'h07c);
        $display("t_abort done");
    endtask
    // foreign device type is ignored
    task automatic t_foreign();
        i2c_master_model_inst.start_c();
        sb({~DT, 3'h0, 1'b0}, 1'b0);
        sb(8'h00, 1'b0);
        sb(8'h11, 1'b0);
        i2c_master_model_inst.stop_c();
        check("m000", {3'h0, mem[11'h000]}, 11'h07e);
        $display("t_foreign done");
    endtask
    initial
    begin
        for (int i = 0; i < 2048; i++)
            mem[i] = 8'(i) ^ 8'h5c;
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        repeat (6) @(posedge link_clk);
        t_write();
        t_read();
        t_wrap();
        t_abort();
        t_foreign();
        give_verdict();
    end
    // watchdog well past the expected run
    initial
    begin
        #400000;
        failures++;
        give_verdict();
    end
endmodule
bind i2c_mem_slave i2c_mem_slave_checker i2c_mem_slave_checker_inst (.clk(clk),
    .arst_n(arst_n), .link_clk(link_clk), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
    .sda_oe(sda_oe), .mem_stb(mem_stb), .mem_cmd(mem_cmd), .mem_rdata(mem_rdata));
`default_nettype wire
